// ### rtl/bmsr_defines.vh
// Purpose: Constants for the boot-mode select and reset entry block
// Assumes: Core clock of 100 MHz
// Notes:   Definitions only, no logic
`ifndef BMSR_DEFINES_VH
`define BMSR_DEFINES_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define BMSR_CLK_MHZ 100
// Boot EPROM access time in ns, least time
`define BMSR_EPROM_ACCESS_NS 100
// Access time in cycles, rounded up, at least one
`define BMSR_EPROM_ACCESS_CYC ((`BMSR_EPROM_ACCESS_NS * `BMSR_CLK_MHZ + 999) / 1000)
// Stages of every pin synchroniser
`define BMSR_SYNC_STAGES 2
// Cycles after reset release before the straps are caught
`define BMSR_STRAP_SETTLE_CYC 3

// ----------------------------------------------------------------
// Boot modes
// ----------------------------------------------------------------
`define BMSR_MODE_W 2
`define BMSR_MODE_NOBOOT 2'h0
`define BMSR_MODE_HOST 2'h1
`define BMSR_MODE_EPROM 2'h2
`define BMSR_MODE_BAD 2'h3

// ----------------------------------------------------------------
// Loader layout and reset values
// ----------------------------------------------------------------
`define BMSR_BYTE_W 8
`define BMSR_WORD_W 48
`define BMSR_BYTES_PER_WORD 3'h6
`define BMSR_BOOT_WORDS 16'h0100
`define BMSR_RESET_VECTOR 24'h000005

`endif

// ### rtl/bmsr_sync2.v
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Destination clock is the core clock
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps

module bmsr_sync2 #(
    parameter WIDTH = 1
) (
    input wire mclk_in,
    input wire reset_n_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ----------------------------------------------------------------
    // Synchroniser stages
    // ----------------------------------------------------------------
    // Two flops, cleared by reset
    always @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // bmsr_sync2

// ### rtl/bmsr_boot_ctrl.v
// Purpose: Boot-mode selection, boot EPROM loader and reset entry
// Assumes: Straps are static board wiring; bus ownership comes from
//          same-clock arbitration logic
// Notes:   Chip select pin is active low, split into in, out, enable
//
// Contract
// - Eprom strap high selects booting from a byte-wide EPROM; the code halts instead when the link strap is also high.
// - Eprom strap low: link strap and chip-select pin pick the mode.
// - In EPROM mode the chip-select pin drives the boot EPROM select.
// - Only the current bus owner drives the chip-select pin.
// - Both straps low, chip-select pin low: no boot, run external memory.
// - Both straps low, chip-select pin high: wait for host boot.
// - Chip-select pin is an output only in EPROM mode, else input.
// - One instruction cycle per input clock period.
// - Reset gives a known state, then starts at the reset vector.
`timescale 1ns/1ps
`include "bmsr_defines.vh"

module bmsr_boot_ctrl #(
    parameter ADDR_W = 16,
    parameter [15:0] BOOT_WORDS = `BMSR_BOOT_WORDS,
    parameter [23:0] RESET_VECTOR = `BMSR_RESET_VECTOR
) (
    input wire mclk_in,
    input wire reset_n_in,
    input wire eprom_boot_strap_in,
    input wire link_boot_strap_in,
    input wire boot_memory_chip_select_in,
    output wire boot_memory_chip_select_out,
    output wire boot_memory_chip_select_oe_out,
    input wire bus_master_in,
    input wire [7:0] eprom_data_in,
    output wire [ADDR_W-1:0] eprom_addr_out,
    input wire host_boot_done_in,
    output wire [1:0] boot_mode_out,
    output wire strap_error_out,
    output wire [47:0] load_word_out,
    output wire [15:0] load_addr_out,
    output wire load_valid_out,
    output wire core_run_out,
    output wire instr_cycle_out,
    output wire fetch_external_out,
    output wire [23:0] start_vector_out
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------
    localparam [2:0] ST_STRAP = 3'h0;
    localparam [2:0] ST_EPROM = 3'h1;
    localparam [2:0] ST_HOST = 3'h2;
    localparam [2:0] ST_RUN = 3'h3;
    localparam [2:0] ST_HALT = 3'h4;
    localparam integer ACC_LAST_I = `BMSR_EPROM_ACCESS_CYC + `BMSR_SYNC_STAGES - 1;
    localparam integer SETTLE_LAST_I = `BMSR_STRAP_SETTLE_CYC - 1;
    localparam [7:0] ACC_LAST = ACC_LAST_I[7:0];
    localparam [1:0] SETTLE_LAST = SETTLE_LAST_I[1:0];
    localparam [2:0] LAST_BYTE = `BMSR_BYTES_PER_WORD - 3'h1;
    localparam [15:0] LAST_WORD = BOOT_WORDS - 16'h0001;

    // ----------------------------------------------------------------
    // Mode decode from the straps
    // ----------------------------------------------------------------
    function [1:0] bmsr_decode;
        input eprom_strap;
        input link_strap;
        input cs_pin;
        begin
            if (eprom_strap && !link_strap)
                bmsr_decode = `BMSR_MODE_EPROM;
            else if (link_strap)
                bmsr_decode = `BMSR_MODE_BAD;
            else if (cs_pin)
                bmsr_decode = `BMSR_MODE_HOST;
            else
                bmsr_decode = `BMSR_MODE_NOBOOT;
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire eprom_strap_s;
    wire link_strap_s;
    wire cs_pin_s;
    wire host_done_s;
    wire [7:0] data_s;

    // Straps, chip-select pin and host handshake
    bmsr_sync2 #(
        .WIDTH(4)
    ) u_sync_ctl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in({eprom_boot_strap_in, link_boot_strap_in,
                   boot_memory_chip_select_in, host_boot_done_in}),
        .sync_out({eprom_strap_s, link_strap_s, cs_pin_s, host_done_s})
    );

    // EPROM data byte
    bmsr_sync2 #(
        .WIDTH(8)
    ) u_sync_data (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(eprom_data_in),
        .sync_out(data_s)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [2:0] state_q;
    reg [1:0] mode_q;
    reg [1:0] settle_q;
    reg access_q;
    reg [7:0] wait_q;
    reg [2:0] byte_idx_q;
    reg [15:0] word_cnt_q;
    reg [47:0] word_q;
    reg [47:0] shift_q;
    reg [15:0] load_addr_q;
    reg load_valid_q;
    reg [ADDR_W-1:0] eprom_addr_q;
    reg run_q;
    reg [23:0] vector_q;

    wire [47:0] shift_d;

    // Low byte arrives first
    assign shift_d = {data_s, shift_q[47:8]};

    // ----------------------------------------------------------------
    // Boot sequencer
    // ----------------------------------------------------------------
    // Known state under reset, straps caught after release
    always @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= ST_STRAP;
            mode_q <= `BMSR_MODE_NOBOOT;
            settle_q <= 2'h0;
            access_q <= 1'b0;
            wait_q <= 8'h00;
            byte_idx_q <= 3'h0;
            word_cnt_q <= 16'h0000;
            word_q <= 48'h000000000000;
            shift_q <= 48'h000000000000;
            load_addr_q <= 16'h0000;
            load_valid_q <= 1'b0;
            eprom_addr_q <= {ADDR_W{1'b0}};
            run_q <= 1'b0;
            vector_q <= 24'h000000;
        end
        else
        begin
            load_valid_q <= 1'b0;
            case (state_q)
                ST_STRAP:
                begin
                    // Wait for the synchronisers to fill, then latch once
                    if (settle_q == SETTLE_LAST)
                    begin
                        mode_q <= bmsr_decode(eprom_strap_s, link_strap_s, cs_pin_s);
                        case (bmsr_decode(eprom_strap_s, link_strap_s, cs_pin_s))
                            `BMSR_MODE_EPROM: state_q <= ST_EPROM;
                            `BMSR_MODE_HOST: state_q <= ST_HOST;
                            `BMSR_MODE_NOBOOT:
                            begin
                                state_q <= ST_RUN;
                                run_q <= 1'b1;
                                vector_q <= RESET_VECTOR;
                            end
                            default: state_q <= ST_HALT;
                        endcase
                    end
                    else
                    begin
                        settle_q <= settle_q + 2'h1;
                    end
                end
                ST_EPROM:
                begin
                    if (!access_q)
                    begin
                        // Start a byte read only while owning the bus
                        if (bus_master_in)
                        begin
                            access_q <= 1'b1;
                            wait_q <= 8'h00;
                        end
                    end
                    else if (!bus_master_in)
                    begin
                        // Lost the bus: drop select, retry this byte
                        access_q <= 1'b0;
                    end
                    else if (wait_q == ACC_LAST)
                    begin
                        access_q <= 1'b0;
                        shift_q <= shift_d;
                        eprom_addr_q <= eprom_addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                        if (byte_idx_q == LAST_BYTE)
                        begin
                            // Full instruction word assembled
                            byte_idx_q <= 3'h0;
                            word_q <= shift_d;
                            load_addr_q <= word_cnt_q;
                            load_valid_q <= 1'b1;
                            word_cnt_q <= word_cnt_q + 16'h0001;
                            if (word_cnt_q == LAST_WORD)
                            begin
                                state_q <= ST_RUN;
                                run_q <= 1'b1;
                                vector_q <= RESET_VECTOR;
                            end
                        end
                        else
                        begin
                            byte_idx_q <= byte_idx_q + 3'h1;
                        end
                    end
                    else
                    begin
                        wait_q <= wait_q + 8'h01;
                    end
                end
                ST_HOST:
                begin
                    // Host loads memory, then releases the core
                    if (host_done_s)
                    begin
                        state_q <= ST_RUN;
                        run_q <= 1'b1;
                        vector_q <= RESET_VECTOR;
                    end
                end
                ST_RUN:
                begin
                    run_q <= 1'b1;
                end
                default:
                begin
                    // Unsupported strap setting: core stays halted
                    run_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Chip-select pin
    // ----------------------------------------------------------------
    // Driven only in EPROM mode and only by the bus owner
    assign boot_memory_chip_select_oe_out = (mode_q == `BMSR_MODE_EPROM) &&
        (state_q != ST_STRAP) && bus_master_in;
    assign boot_memory_chip_select_out = ~access_q;

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign eprom_addr_out = eprom_addr_q;
    assign boot_mode_out = mode_q;
    assign strap_error_out = (state_q == ST_HALT);
    assign load_word_out = word_q;
    assign load_addr_out = load_addr_q;
    assign load_valid_out = load_valid_q;
    assign core_run_out = run_q;
    // One instruction slot per core clock while running
    assign instr_cycle_out = run_q;
    assign fetch_external_out = run_q && (mode_q == `BMSR_MODE_NOBOOT);
    assign start_vector_out = vector_q;

endmodule // bmsr_boot_ctrl

// ### testbench/bmsr_boot_ctrl_monitor.sv
// Purpose: Port checks for the boot-mode and reset entry block
// Assumes: One core clock, async active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`include "bmsr_defines.vh"

module bmsr_boot_ctrl_monitor #(
    parameter [23:0] RESET_VECTOR = `BMSR_RESET_VECTOR
) (
    input wire mclk_in,
    input wire reset_n_in,
    input wire bus_master_in,
    input wire host_boot_done_in,
    input wire boot_memory_chip_select_out,
    input wire boot_memory_chip_select_oe_out,
    input wire [1:0] boot_mode_out,
    input wire strap_error_out,
    input wire load_valid_out,
    input wire core_run_out,
    input wire instr_cycle_out,
    input wire fetch_external_out,
    input wire [23:0] start_vector_out
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Pin drive only by the bus owner in EPROM mode
    oe_owner_a: assert property (boot_memory_chip_select_oe_out |-> bus_master_in)
        else $error("pin driven without the bus");
    oe_mode_a: assert property (boot_memory_chip_select_oe_out |-> boot_mode_out == 2'h2)
        else $error("pin driven outside EPROM mode");
    cs_mode_a: assert property (!boot_memory_chip_select_out |-> boot_mode_out == 2'h2)
        else $error("chip select low outside EPROM mode");
    // Words are six bytes apart, so pulses never crowd
    valid_gap_a: assert property (load_valid_out |=> !load_valid_out [*8])
        else $error("load pulses too close");
    ext_fetch_a: assert property (fetch_external_out == (core_run_out && boot_mode_out == 2'h0))
        else $error("external fetch wrong");
    instr_rate_a: assert property (instr_cycle_out == core_run_out)
        else $error("instruction cycle not per clock");
    vector_a: assert property (core_run_out |-> start_vector_out == RESET_VECTOR)
        else $error("start vector wrong");
    mode_hold_a: assert property (core_run_out |=> core_run_out && $stable(boot_mode_out))
        else $error("mode or run changed");
    halt_a: assert property (strap_error_out |-> !core_run_out && boot_mode_out == 2'h3)
        else $error("halt state not kept");
    host_gate_a: assert property ($rose(core_run_out) && boot_mode_out == 2'h1
        |-> $past(host_boot_done_in, 2)) else $error("host run without done");
    cover property (load_valid_out);
    cover property (fetch_external_out);
    cover property (strap_error_out);
    cover property ($rose(core_run_out) && boot_mode_out == 2'h1);
endmodule // bmsr_boot_ctrl_monitor

bind bmsr_boot_ctrl bmsr_boot_ctrl_monitor #(.RESET_VECTOR(RESET_VECTOR)) mon (
    .mclk_in, .reset_n_in, .bus_master_in, .host_boot_done_in, .boot_memory_chip_select_out,
    .boot_memory_chip_select_oe_out, .boot_mode_out, .strap_error_out, .load_valid_out,
    .core_run_out, .instr_cycle_out, .fetch_external_out, .start_vector_out
);

// ### testbench/bmsr_eprom_model.sv
// Purpose: Byte-wide boot EPROM model
// Assumes: Active-low chip select, fixed access time
// Notes:   Data is a pattern of the byte address
`timescale 1ns/1ps

module bmsr_eprom_model #(
    parameter ACCESS_NS = 80
) (
    input wire cs_n_in,
    input wire [15:0] addr_in,
    output reg [7:0] data_out
);
    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    initial data_out = 8'h00;

    // Released bus shows the inverse, data after access time
    always @(cs_n_in or addr_in)
    begin
        data_out = ~data_out;
        if (!cs_n_in)
            data_out <= #(ACCESS_NS) addr_in[7:0] ^ 8'h5a;
    end
endmodule // bmsr_eprom_model

// ### testbench/bmsr_boot_ctrl_tb.sv
// Purpose: Self-checking bench for the boot-mode and reset entry block
// Assumes: 100 MHz clock, two boot words for a short run
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`include "bmsr_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module bmsr_boot_ctrl_tb;
    // ----------------------------------------------------------------
    // Bench
    // ----------------------------------------------------------------
    localparam [15:0] WORDS = 16'h0002;
    reg mclk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg eprom_strap = 1'b0;
    reg link_s = 1'b0;
    reg cs_strap = 1'b0;
    reg bus_master_in = 1'b0;
    reg host_done = 1'b0;
    reg [31:0] lfsr_q = 32'h72665373;
    int fails = 0;
    int compares = 0;
    int n;
    int i;
    wire cs_out, cs_oe, ld_valid, run, instr, fetch_ext, strap_err;
    wire [7:0] rom_data;
    wire [15:0] rom_addr, ld_addr;
    wire [1:0] mode;
    wire [47:0] ld_word;
    wire [23:0] vec;
    wire cs_pin = cs_oe ? cs_out : cs_strap; // Our drive, else board strap

    // Free-running core clock, never stopped
    always #5 mclk_in = ~mclk_in;

    bmsr_boot_ctrl #(.BOOT_WORDS(WORDS)) dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .eprom_boot_strap_in(eprom_strap),
        .link_boot_strap_in(link_s), .boot_memory_chip_select_in(cs_pin),
        .boot_memory_chip_select_out(cs_out), .boot_memory_chip_select_oe_out(cs_oe),
        .bus_master_in(bus_master_in), .eprom_data_in(rom_data), .eprom_addr_out(rom_addr),
        .host_boot_done_in(host_done), .boot_mode_out(mode), .strap_error_out(strap_err),
        .load_word_out(ld_word), .load_addr_out(ld_addr), .load_valid_out(ld_valid),
        .core_run_out(run), .instr_cycle_out(instr), .fetch_external_out(fetch_ext),
        .start_vector_out(vec)
    );
    bmsr_eprom_model rom (.cs_n_in(cs_pin), .addr_in(rom_addr), .data_out(rom_data));

    function [31:0] lfsr_next;
        begin
            lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
            lfsr_next = lfsr_q;
        end
    endfunction

    // Six bytes, first byte lowest
    function [47:0] exp_word(input int w);
        int k;
        begin
            for (k = 0; k < 6; k++)
                exp_word[k*8 +: 8] = 8'(w * 6 + k) ^ 8'h5a;
        end
    endfunction

    task tick;
        begin
            @(posedge mclk_in);
            #1;
        end
    endtask

    // Reset for 4 cycles with straps set, then past the mode latch
    task start(input logic e, input logic l, input logic b);
        begin
            reset_n_in = 1'b0;
            eprom_strap = e;
            link_s = l;
            cs_strap = b;
            repeat (4) tick;
            reset_n_in = 1'b1;
            repeat (5) tick;
        end
    endtask

    task close_out;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial
    begin
        // No boot: external fetch at once, pin never driven
        bus_master_in = 1'b1;
        start(1'b0, 1'b0, 1'b0);
        `CHK(mode, `BMSR_MODE_NOBOOT)
        `CHK(fetch_ext, 1'b1)
        `CHK(instr, 1'b1)
        `CHK(vec, `BMSR_RESET_VECTOR)
        `CHK(cs_oe, 1'b0)
        // Link strap high halts for every other strap value
        for (i = 0; i < 4; i++)
        begin
            start(i[0], 1'b1, i[1]);
            `CHK(strap_err, 1'b1)
            `CHK(run, 1'b0)
            `CHK(cs_oe, 1'b0)
        end
        // Host boot; later strap changes are ignored
        start(1'b0, 1'b0, 1'b1);
        `CHK(mode, `BMSR_MODE_HOST)
        cs_strap = 1'b0;
        eprom_strap = 1'b1;
        repeat (lfsr_next() % 20 + 2) tick;
        `CHK(run, 1'b0)
        host_done = 1'b1;
        repeat (3) tick;
        `CHK(run, 1'b1)
        `CHK(mode, `BMSR_MODE_HOST)
        `CHK(fetch_ext, 1'b0)
        // EPROM boot with random bus loss, host line left high
        start(1'b1, 1'b0, lfsr_q[3]);
        `CHK(mode, `BMSR_MODE_EPROM)
        n = 0;
        for (i = 0; i < 8000 && run !== 1'b1; i++)
        begin
            bus_master_in = (lfsr_next() % 16) != 0;
            tick;
            `CHK(cs_oe, bus_master_in)
            if (ld_valid === 1'b1)
            begin
                `CHK(ld_addr, n[15:0])
                `CHK(ld_word, exp_word(n))
                `CHK(run, n == WORDS - 1)
                n++;
            end
        end
        `CHK(n, WORDS)
        `CHK(rom_addr, 16'(WORDS * 6))
        `CHK(cs_out, 1'b1)
        `CHK(vec, `BMSR_RESET_VECTOR)
        close_out;
    end

    // Hang guard, far beyond the expected run
    initial
    begin
        #200000;
        fails++;
        close_out;
    end
endmodule // bmsr_boot_ctrl_tb
